// >>> rtl/pdm_ctrl.sv
// Purpose: Power-down mode controller with Wishbone register access
// Assumes: Single clock, synchronous reset; CPU signals sleep and accepted interrupts
// Notes:   Outputs are registered gates and enables for the peripherals
`timescale 1ns/1ps
module pdm_ctrl
	import pdm_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Wishbone slave
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [15:0]           adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	// CPU events, same clock
	input  wire logic                  sleep_exec_i,
	input  wire logic                  irq_accept_i,
	// Wake-up request levels from pins
	input  wire logic [PDM_NWKP-1:0]   wake_up_pin_input_i,
	input  wire logic [PDM_NIRQ-1:0]   ext_irq_i,
	// Peripheral interrupt requests, same clock
	input  wire logic                  tka_irq_i,
	input  wire logic                  tmc_irq_i,
	input  wire logic                  tmf_irq_i,
	input  wire logic                  tmg_irq_i,
	input  wire logic                  sc1_irq_i,
	input  wire logic                  sc2_irq_i,
	input  wire logic                  aec_irq_i,
	// Peripheral clock selections
	input  wire logic [2:0]            tmc_cksel_i,
	input  wire logic [2:0]            tmf_cksel_i,
	input  wire logic [2:0]            tmg_cksel_i,
	input  wire logic [2:0]            sc1_cksel_i,
	input  wire logic [2:0]            sc2_cksel_i,
	input  wire logic [2:0]            lcd_cksel_i,
	input  wire logic [2:0]            wdt_cksel_i,
	input  wire logic                  tka_timebase_i,
	// Mode and control outputs
	output logic      [5:0]            mode_o,
	output logic                       sys_osc_en_o,
	output logic                       sub_osc_en_o,
	output logic                       cpu_run_o,
	output logic                       port_oe_o,
	output logic                       tka_run_o,
	output logic                       tmc_run_o,
	output logic                       tmf_run_o,
	output logic                       tmg_run_o,
	output logic                       sc1_run_o,
	output logic                       sc2_run_o,
	output logic                       sc_rst_o,
	output logic                       lcd_run_o,
	output logic                       wdt_run_o,
	output logic                       async_event_counter_inc_en_o,
	output logic                       async_event_counter_irq_en_o,
	output logic      [PDM_NIRQ-1:0]   ext_irq_flag_o,
	output logic                       wake_o
);
	// ============================================================
	// Declarations
	logic [7:0]           mode_control_first_ff;
	logic [7:0]           mode_control_second_ff;
	pdm_mode_t            mode_ff;
	pdm_mode_t            nxt_mode;
	logic                 wake_pend_ff;
	logic                 nxt_wake;
	logic [PDM_NWKP-1:0]  wkp_s;
	logic [PDM_NIRQ-1:0]  irq_s;
	logic [PDM_NIRQ-1:0]  irq_d_ff;
	logic [PDM_NIRQ-1:0]  irq_edge;
	logic [PDM_NIRQ-1:0]  irq_served;
	logic                 sub_mode;
	logic                 wr_req;
	logic                 cls_watch;
	logic                 cls_sub;
	logic                 software_standby_bit;
	logic                 lson;
	logic                 dton;

	// Clock selections that keep a peripheral running
	function automatic logic ck_ext_w4(input logic [2:0] ck);
		ck_ext_w4 = (ck == PDM_CK_EXT) || (ck == PDM_CK_W4);
	endfunction
	function automatic logic ck_w2(input logic [2:0] ck);
		ck_w2 = (ck == PDM_CK_W2);
	endfunction

	// ============================================================
	// Pin synchronisers
	pdm_sync #(.W(PDM_NWKP + PDM_NIRQ)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({wake_up_pin_input_i, ext_irq_i}),
		.q_o   ({wkp_s, irq_s})
	);

	// ============================================================
	// Wishbone slave, one-cycle registered ack
	assign wr_req = cyc_i && stb_i && we_i && ack_o && sel_i[0]; // Lands on the ack edge

	// Ack generation, drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i && stb_i && !ack_o && !we_i) begin
			case (adr_i)
				PDM_ADR_CTL1: dat_o <= {24'h00_0000, mode_control_first_ff};
				PDM_ADR_CTL2: dat_o <= {24'h00_0000, mode_control_second_ff};
				default:      dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// First mode control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_control_first_ff <= PDM_RST_CTL1;
		end else if (wr_req && adr_i == PDM_ADR_CTL1) begin
			mode_control_first_ff <= dat_i[7:0] | PDM_RSV_CTL1;
		end
	end

	// Second mode control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_control_second_ff <= PDM_RST_CTL2;
		end else if (wr_req && adr_i == PDM_ADR_CTL2) begin
			mode_control_second_ff <= dat_i[7:0];
		end
	end

	assign software_standby_bit = mode_control_first_ff[PDM_B_SOFTWARE_STANDBY_BIT];
	assign lson = mode_control_first_ff[PDM_B_LSON];
	assign dton = mode_control_second_ff[PDM_B_DTON];

	// ============================================================
	// Wake-up source classes
	assign cls_watch = tka_irq_i || tmf_irq_i || tmg_irq_i || irq_edge[0]
		|| (|wkp_s);
	assign cls_sub = cls_watch || tmc_irq_i || sc1_irq_i || sc2_irq_i
		|| (|irq_edge) || aec_irq_i;

	// Wake qualifier per current mode
	always_comb begin
		nxt_wake = 1'b0;
		case (mode_ff)
			PDM_SLEEP:     nxt_wake = cls_sub;   // Any live source, none means stay
			PDM_SUBSLEEP:  nxt_wake = cls_sub;
			PDM_WATCH:     nxt_wake = cls_watch;
			PDM_STANDBY:   nxt_wake = cls_watch;
			default:       nxt_wake = 1'b0;
		endcase
	end

	// Pending wake: set by a source, consumed by acceptance, set wins; running modes drop it
	always_ff @(posedge clk_i) begin
		if (rst_i || mode_ff == PDM_ACTIVE || mode_ff == PDM_SUBACTIVE) begin
			wake_pend_ff <= 1'b0;
		end else if (nxt_wake) begin
			wake_pend_ff <= 1'b1;
		end else if (irq_accept_i) begin
			wake_pend_ff <= 1'b0;
		end
	end

	// ============================================================
	// Mode sequencer
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			PDM_ACTIVE: begin
				if (sleep_exec_i) begin
					if (!software_standby_bit) begin
						nxt_mode = PDM_SLEEP;
					end else if (tka_timebase_i) begin
						nxt_mode = dton ? (lson ? PDM_SUBACTIVE : PDM_ACTIVE)
							: PDM_WATCH;
					end else begin
						nxt_mode = PDM_STANDBY;
					end
				end
			end
			PDM_SUBACTIVE: begin
				if (sleep_exec_i) begin
					if (!software_standby_bit) begin
						nxt_mode = PDM_SUBSLEEP;
					end else if (dton) begin
						nxt_mode = lson ? PDM_SUBACTIVE : PDM_ACTIVE;
					end else begin
						nxt_mode = tka_timebase_i ? PDM_WATCH : PDM_STANDBY;
					end
				end
			end
			PDM_SLEEP, PDM_STANDBY: begin
				if (wake_pend_ff && irq_accept_i) begin
					nxt_mode = PDM_ACTIVE;
				end
			end
			PDM_SUBSLEEP, PDM_WATCH: begin
				if (wake_pend_ff && irq_accept_i) begin
					nxt_mode = lson ? PDM_SUBACTIVE : PDM_ACTIVE;
				end
			end
			default: nxt_mode = PDM_ACTIVE;
		endcase
	end

	// Mode register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= PDM_ACTIVE;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	assign sub_mode = (mode_ff == PDM_WATCH) || (mode_ff == PDM_SUBACTIVE)
		|| (mode_ff == PDM_SUBSLEEP);

	// ============================================================
	// External request flags one to five
	assign irq_served = (mode_ff == PDM_WATCH || mode_ff == PDM_STANDBY)
		? {{(PDM_NIRQ-1){1'b0}}, 1'b1} : {PDM_NIRQ{1'b1}};
	assign irq_edge = irq_s & ~irq_d_ff & irq_served;

	// Edge history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_d_ff <= '0;
		end else begin
			irq_d_ff <= irq_s;
		end
	end

	// Flags set by served edges, cleared on acceptance; set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_irq_flag_o <= '0;
		end else begin
			ext_irq_flag_o <= (irq_accept_i ? '0 : ext_irq_flag_o) | irq_edge;
		end
	end

	// ============================================================
	// Registered gating outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_o                       <= PDM_ACTIVE;
			sys_osc_en_o                 <= 1'b1;
			sub_osc_en_o                 <= 1'b1;
			cpu_run_o                    <= 1'b1;
			port_oe_o                    <= 1'b1;
			tka_run_o                    <= 1'b1;
			tmc_run_o                    <= 1'b1;
			tmf_run_o                    <= 1'b1;
			tmg_run_o                    <= 1'b1;
			sc1_run_o                    <= 1'b1;
			sc2_run_o                    <= 1'b1;
			sc_rst_o                     <= 1'b0;
			lcd_run_o                    <= 1'b1;
			wdt_run_o                    <= 1'b1;
			async_event_counter_inc_en_o <= 1'b1;
			async_event_counter_irq_en_o <= 1'b1;
			wake_o                       <= 1'b0;
		end else begin
			mode_o       <= mode_ff;
			sys_osc_en_o <= (mode_ff == PDM_ACTIVE) || (mode_ff == PDM_SLEEP);
			sub_osc_en_o <= 1'b1;
			cpu_run_o    <= (mode_ff == PDM_ACTIVE) || (mode_ff == PDM_SUBACTIVE);
			port_oe_o    <= (mode_ff != PDM_STANDBY);
			tka_run_o    <= (mode_ff == PDM_STANDBY) ? 1'b0
				: (!sub_mode || tka_timebase_i);
			tmc_run_o    <= (mode_ff == PDM_STANDBY || mode_ff == PDM_WATCH) ? 1'b0
				: (!sub_mode || ck_ext_w4(tmc_cksel_i));
			tmf_run_o    <= (mode_ff == PDM_STANDBY) ? 1'b0
				: (!sub_mode || ck_ext_w4(tmf_cksel_i));
			tmg_run_o    <= (mode_ff == PDM_STANDBY) ? 1'b0
				: (!sub_mode || ck_ext_w4(tmg_cksel_i));
			sc1_run_o    <= (mode_ff == PDM_STANDBY || mode_ff == PDM_WATCH) ? 1'b0
				: (!sub_mode || ck_w2(sc1_cksel_i));
			sc2_run_o    <= (mode_ff == PDM_STANDBY || mode_ff == PDM_WATCH) ? 1'b0
				: (!sub_mode || ck_w2(sc2_cksel_i));
			sc_rst_o     <= (mode_ff == PDM_STANDBY) || (mode_ff == PDM_WATCH);
			lcd_run_o    <= (mode_ff == PDM_STANDBY) ? 1'b0
				: (!sub_mode || lcd_cksel_i == PDM_CK_W || lcd_cksel_i == PDM_CK_W2
				|| lcd_cksel_i == PDM_CK_W4);
			wdt_run_o    <= (mode_ff == PDM_ACTIVE) || (mode_ff == PDM_SLEEP)
				|| (mode_ff == PDM_SUBACTIVE && wdt_cksel_i == PDM_CK_W32);
			async_event_counter_inc_en_o <= 1'b1;
			async_event_counter_irq_en_o <= !(mode_ff == PDM_STANDBY
				|| mode_ff == PDM_WATCH);
			wake_o       <= wake_pend_ff;
		end
	end

	// ============================================================
	// Checks
	sequence s_sleep_cmd;
		mode_ff == PDM_ACTIVE && sleep_exec_i && !software_standby_bit;
	endsequence
	property p_sleep_entry;
		@(posedge clk_i) disable iff (rst_i) s_sleep_cmd |=> mode_ff == PDM_SLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

	property p_no_raw_wake;
		@(posedge clk_i) disable iff (rst_i)
		(mode_ff == PDM_SLEEP && !irq_accept_i) |=> mode_ff == PDM_SLEEP;
	endproperty
	a_no_raw_wake: assert property (p_no_raw_wake) else $error("mode left without accept");

	property p_port_hiz;
		@(posedge clk_i) disable iff (rst_i) mode_ff == PDM_STANDBY |=> !port_oe_o;
	endproperty
	a_port_hiz: assert property (p_port_hiz) else $error("ports driven in standby");

	property p_sc_reset;
		@(posedge clk_i) disable iff (rst_i)
		(mode_ff == PDM_WATCH) |=> sc_rst_o && !sc1_run_o && !sc2_run_o;
	endproperty
	a_sc_reset: assert property (p_sc_reset) else $error("serial not reset in watch");

	property p_osc;
		@(posedge clk_i) disable iff (rst_i)
		sub_mode |=> !sys_osc_en_o && sub_osc_en_o;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator gating wrong");

	property p_aec_irq;
		@(posedge clk_i) disable iff (rst_i)
		(mode_ff == PDM_WATCH) |=> !async_event_counter_irq_en_o
			&& async_event_counter_inc_en_o;
	endproperty
	a_aec_irq: assert property (p_aec_irq) else $error("counter irq in watch");

	property p_irq_ignored;
		@(posedge clk_i) disable iff (rst_i)
		(mode_ff == PDM_WATCH && !irq_accept_i)
			|=> ext_irq_flag_o[PDM_NIRQ-1:1] == $past(ext_irq_flag_o[PDM_NIRQ-1:1]);
	endproperty
	a_irq_ignored: assert property (p_irq_ignored) else $error("request flag altered");

	property p_wdt;
		@(posedge clk_i) disable iff (rst_i)
		(mode_ff == PDM_SUBACTIVE && wdt_cksel_i != PDM_CK_W32) |=> !wdt_run_o;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog ran on wrong clock");

	property p_ctl1_reset;
		@(posedge clk_i) rst_i |=> mode_control_first_ff == PDM_RST_CTL1
			&& mode_control_second_ff == PDM_RST_CTL2;
	endproperty
	a_ctl1_reset: assert property (p_ctl1_reset) else $error("bad reset value");
endmodule // pdm_ctrl

// >>> rtl/pdm_pkg.sv
// Purpose: Constants and types for the power-down mode controller
// Assumes: 20 MHz system clock, classic Wishbone register access
// Notes:   Mode control registers sit at byte addresses 0xfff0 and 0xfff1
// ============================================================
package pdm_pkg;
	// ============================================================
	// Register map
	localparam logic [15:0] PDM_ADR_CTL1 = 16'hfff0;
	localparam logic [15:0] PDM_ADR_CTL2 = 16'hfff1;
	localparam logic [7:0]  PDM_RST_CTL1 = 8'h07;
	localparam logic [7:0]  PDM_RST_CTL2 = 8'hf0;
	localparam logic [7:0]  PDM_RSV_CTL1 = 8'h04; // Reserved bit 2 reads one
	// First register fields
	localparam int PDM_B_SOFTWARE_STANDBY_BIT = 7;
	localparam int PDM_B_LSON = 3;
	// Second register fields
	localparam int PDM_B_MSON = 2;
	localparam int PDM_B_DTON = 3;
	// Clock-select codes seen on peripheral select inputs
	localparam logic [2:0] PDM_CK_OTHER = 3'h0;
	localparam logic [2:0] PDM_CK_EXT   = 3'h1;
	localparam logic [2:0] PDM_CK_W     = 3'h2;
	localparam logic [2:0] PDM_CK_W2    = 3'h3;
	localparam logic [2:0] PDM_CK_W4    = 3'h4;
	localparam logic [2:0] PDM_CK_W32   = 3'h5;
	// Widths
	localparam int PDM_NWKP = 8;
	localparam int PDM_NIRQ = 5;
	// Modes, one-hot
	typedef enum logic [5:0] {
		PDM_ACTIVE    = 6'h01,
		PDM_SLEEP     = 6'h02,
		PDM_SUBACTIVE = 6'h04,
		PDM_SUBSLEEP  = 6'h08,
		PDM_WATCH     = 6'h10,
		PDM_STANDBY   = 6'h20
	} pdm_mode_t;
endpackage

// >>> rtl/pdm_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Inputs asynchronous to clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module pdm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	// Two-stage capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			q_o     <= '0;
		end else begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end
endmodule // pdm_sync

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the power-down mode controller
// Assumes: Ack one cycle after a taken request; outputs one cycle behind mode
// Notes:   All stimulus by non-blocking assignment right after rising edges
`timescale 1ns/1ps
module testbench;
	import pdm_pkg::*;
	// ============================================================
	// Clock, reset and design inputs
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [15:0]         adr_i = 16'h0000;
	logic [3:0]          sel_i = 4'h0;
	logic [31:0]         dat_i = 32'h0000_0000;
	logic [31:0]         dat_o;
	logic                ack_o;
	logic                sleep_exec_i = 1'b0, irq_accept_i = 1'b0;
	logic [PDM_NWKP-1:0] wkp_i = '0;
	logic [PDM_NIRQ-1:0] ext_irq_i = '0;
	logic                tka_irq_i = 1'b0, tmc_irq_i = 1'b0, tmf_irq_i = 1'b0, tmg_irq_i = 1'b0;
	logic                sc1_irq_i = 1'b0, sc2_irq_i = 1'b0, aec_irq_i = 1'b0;
	logic [2:0]          tmc_ck = PDM_CK_OTHER, tmf_ck = PDM_CK_OTHER, tmg_ck = PDM_CK_OTHER;
	logic [2:0]          sc1_ck = PDM_CK_OTHER, sc2_ck = PDM_CK_OTHER, lcd_ck = PDM_CK_OTHER;
	logic [2:0]          wdt_ck = PDM_CK_OTHER;
	logic                tbase = 1'b0;
	logic [5:0]          mode_o;
	logic                sys_osc, sub_osc, cpu_run, port_oe, tka_run, tmc_run, tmf_run, tmg_run;
	logic                sc1_run, sc2_run, sc_rst, lcd_run, wdt_run, aec_inc, aec_irq_en, wake_o;
	logic [PDM_NIRQ-1:0] flags;
	int                  bad_count = 0;
	int                  num_checks = 0;
	logic [31:0]         rdat;

	// 20 MHz clock
	always #25 clk_i = ~clk_i;

	pdm_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.sleep_exec_i(sleep_exec_i), .irq_accept_i(irq_accept_i),
		.wake_up_pin_input_i(wkp_i), .ext_irq_i(ext_irq_i), .tka_irq_i(tka_irq_i),
		.tmc_irq_i(tmc_irq_i), .tmf_irq_i(tmf_irq_i), .tmg_irq_i(tmg_irq_i),
		.sc1_irq_i(sc1_irq_i), .sc2_irq_i(sc2_irq_i), .aec_irq_i(aec_irq_i),
		.tmc_cksel_i(tmc_ck), .tmf_cksel_i(tmf_ck), .tmg_cksel_i(tmg_ck),
		.sc1_cksel_i(sc1_ck), .sc2_cksel_i(sc2_ck), .lcd_cksel_i(lcd_ck),
		.wdt_cksel_i(wdt_ck), .tka_timebase_i(tbase), .mode_o(mode_o),
		.sys_osc_en_o(sys_osc), .sub_osc_en_o(sub_osc), .cpu_run_o(cpu_run),
		.port_oe_o(port_oe), .tka_run_o(tka_run), .tmc_run_o(tmc_run), .tmf_run_o(tmf_run),
		.tmg_run_o(tmg_run), .sc1_run_o(sc1_run), .sc2_run_o(sc2_run), .sc_rst_o(sc_rst),
		.lcd_run_o(lcd_run), .wdt_run_o(wdt_run), .async_event_counter_inc_en_o(aec_inc),
		.async_event_counter_irq_en_o(aec_irq_en), .ext_irq_flag_o(flags), .wake_o(wake_o));

	// ============================================================
	// Compare and closing tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t value got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ============================================================
	// Wishbone classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] wd,
		input logic [3:0] s, output logic [31:0] rd);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= wd;
		sel_i <= s;
		// Only the watchdog ends a missing acknowledge
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		wb(1'b1, a, {24'h0, d}, 4'h1, rdat);
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		wb(1'b0, a, 32'h0, 4'hf, rdat);
		chk(rdat, {24'h0, exp});
	endtask

	// ============================================================
	// CPU event pulses and wake wait
	task automatic ev(input logic is_sleep);
		@(posedge clk_i);
		if (is_sleep) sleep_exec_i <= 1'b1;
		else irq_accept_i <= 1'b1;
		@(posedge clk_i);
		sleep_exec_i <= 1'b0;
		irq_accept_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic wait_wake();
		int n;
		n = 0;
		while (wake_o !== 1'b1 && n < 12) begin
			@(posedge clk_i);
			n++;
		end
		chk_bit(wake_o, 1'b1);
	endtask

	task automatic settle();
		repeat (4) @(posedge clk_i);
	endtask

	// ============================================================
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end

	// ============================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(PDM_ADR_CTL1, PDM_RST_CTL1);
		rd_chk(PDM_ADR_CTL2, PDM_RST_CTL2);
		chk(32'(mode_o), 32'(PDM_ACTIVE));
		wr(PDM_ADR_CTL1, 8'h00);
		rd_chk(PDM_ADR_CTL1, PDM_RSV_CTL1);
		wb(1'b1, PDM_ADR_CTL2, 32'h0000_0033, 4'h2, rdat);
		rd_chk(PDM_ADR_CTL2, PDM_RST_CTL2);
		wr(16'hfff2, 8'h5a);
		rd_chk(16'hfff2, 8'h00);
		// Request three counted in active mode
		ext_irq_i[2] <= 1'b1;
		settle();
		chk(32'(flags), 32'h04);
		ext_irq_i[2] <= 1'b0;
		// Sleep, refused accept, then wake on timer C
		ev(1'b1);
		chk(32'(mode_o), 32'(PDM_SLEEP));
		chk_bit(cpu_run, 1'b0);
		ev(1'b0);
		chk(32'(mode_o), 32'(PDM_SLEEP));
		tmc_irq_i <= 1'b1;
		settle();
		chk(32'(mode_o), 32'(PDM_SLEEP));
		wait_wake();
		ev(1'b0);
		tmc_irq_i <= 1'b0;
		chk(32'(mode_o), 32'(PDM_ACTIVE));
		// Watch mode
		wr(PDM_ADR_CTL1, 8'h80);
		tbase  <= 1'b1;
		lcd_ck <= PDM_CK_W;
		tmf_ck <= PDM_CK_W4;
		settle();
		ev(1'b1);
		chk(32'(mode_o), 32'(PDM_WATCH));
		chk({sys_osc, sub_osc, sc_rst}, 32'h3);
		chk({aec_inc, aec_irq_en, tka_run, lcd_run, tmf_run}, 32'h17);
		lcd_ck <= PDM_CK_OTHER;
		ext_irq_i[1] <= 1'b1;
		tmc_irq_i <= 1'b1;
		settle();
		chk_bit(lcd_run, 1'b0);
		// Earlier accepts cleared every flag; request two must not set one
		chk(32'(flags), 32'h00);
		chk_bit(wake_o, 1'b0);
		tmc_irq_i <= 1'b0;
		ext_irq_i[1] <= 1'b0;
		tmf_irq_i <= 1'b1;
		wait_wake();
		ev(1'b0);
		tmf_irq_i <= 1'b0;
		chk(32'(mode_o), 32'(PDM_ACTIVE));
		// Standby mode
		tbase <= 1'b0;
		settle();
		ev(1'b1);
		chk(32'(mode_o), 32'(PDM_STANDBY));
		chk({port_oe, sys_osc, sub_osc, sc_rst, aec_irq_en}, 32'h6);
		tmg_irq_i <= 1'b1;
		wait_wake();
		ev(1'b0);
		tmg_irq_i <= 1'b0;
		settle();
		chk({port_oe, sys_osc}, 32'h3);
		// Direct transfer to subactive
		wr(PDM_ADR_CTL2, 8'hf8);
		wr(PDM_ADR_CTL1, 8'h88);
		tbase  <= 1'b1; // Direct transfer needs the time base selected
		tmc_ck <= PDM_CK_EXT;
		tmg_ck <= PDM_CK_OTHER;
		sc1_ck <= PDM_CK_W2;
		sc2_ck <= PDM_CK_W4;
		wdt_ck <= PDM_CK_W32;
		settle();
		ev(1'b1);
		chk(32'(mode_o), 32'(PDM_SUBACTIVE));
		chk({sys_osc, sub_osc, cpu_run}, 32'h3);
		chk({tmc_run, tmg_run, sc1_run, sc2_run, wdt_run}, 32'h15);
		wdt_ck <= PDM_CK_W4;
		settle();
		chk_bit(wdt_run, 1'b0);
		// Subsleep and wake on serial channel one
		wr(PDM_ADR_CTL1, 8'h08);
		ev(1'b1);
		chk(32'(mode_o), 32'(PDM_SUBSLEEP));
		chk({sys_osc, cpu_run}, 32'h0);
		sc1_irq_i <= 1'b1;
		wait_wake();
		ev(1'b0);
		sc1_irq_i <= 1'b0;
		chk(32'(mode_o), 32'(PDM_SUBACTIVE));
		stop_test();
	end
endmodule // testbench
